// [common/oom_params.svh]
// Offsets, field positions, reset values and selector codes of the observation mux
`ifndef OOM_PARAMS_SVH
`define OOM_PARAMS_SVH

// Serial frame layout: one direction bit, six address bits, 24 data bits
`define OOM_ADDR_W 6
`define OOM_DATA_W 24
`define OOM_FRAME_W 5'd31
`define OOM_HEAD_W 5'd7

// Register offsets
`define OOM_OFS_FRAC 6'h0C
`define OOM_OFS_AUX_A 6'h18
`define OOM_OFS_AUX_B 6'h19
`define OOM_OFS_VIEW 6'h1B
`define OOM_OFS_STATUS 6'h1F

// Reset value of every writable register
`define OOM_REG_RESET 24'h000000

// Field positions of the view configuration register
`define OOM_SEL_MSB 3
`define OOM_SEL_LSB 0
`define OOM_DATA0_MSB 6
`define OOM_DATA0_LSB 4

// Field positions of the auxiliary clock registers
`define OOM_AUX_RING_BIT 0
`define OOM_AUX_XTAL_BIT 0
`define OOM_AUX_DLY_MSB 3
`define OOM_AUX_DLY_LSB 2
`define OOM_AUX_DIV_MSB 6
`define OOM_AUX_DIV_LSB 4
`define OOM_AUX_DIV_BYPASS 3'h7
`define OOM_AUX_DLY_STAGES 3

// Status register bit
`define OOM_STAT_PULLIN_BIT 0

// Selector codes
`define OOM_VIEW_DATA 4'h0
`define OOM_VIEW_PATHS 4'h1
`define OOM_VIEW_LOCKWIN 4'h2
`define OOM_VIEW_SLIP 4'h3
`define OOM_VIEW_FRAC 4'h4
`define OOM_VIEW_ACCUM 4'h6
`define OOM_VIEW_AUX 4'h7
`define OOM_VIEW_DSMOUT 4'hA

`endif

// [common/oom_pkg.sv]
// Types shared by the observation mux design
package oom_pkg;
    typedef logic [23:0] oom_word_t;
    typedef logic [5:0] oom_addr_t;
    typedef enum logic [1:0] {OOM_SER_IDLE, OOM_SER_SHIFT, OOM_SER_DONE} oom_ser_state_t;
endpackage : oom_pkg

// [logic/oom_aux_clock.sv]
// Auxiliary clock source select, even divider and delay line
`timescale 1ns/1ps
`include "oom_params.svh"
module oom_aux_clock
    import oom_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control words
    input wire oom_word_t aux_ctrl_a,
    input wire oom_word_t aux_ctrl_b,
    // Candidate sources
    input wire logic vco_clk_in,
    input wire logic xtal_clk_in,
    input wire logic ring_osc_in,
    // Result
    output logic aux_clk
);
    logic src;
    logic src_prev_reg, src_prev_next;
    logic [2:0] cnt_reg, cnt_next;
    logic div_reg, div_next;
    logic [`OOM_AUX_DLY_STAGES-1:0] dly_reg, dly_next;
    logic aux_next;
    logic [2:0] div_code;
    logic [1:0] dly_sel;

    assign div_code = aux_ctrl_a[`OOM_AUX_DIV_MSB:`OOM_AUX_DIV_LSB];
    assign dly_sel = aux_ctrl_a[`OOM_AUX_DLY_MSB:`OOM_AUX_DLY_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Delay line stages
    assign dly_next[0] = div_reg;
    genvar gi;
    generate
        for (gi = 1; gi < `OOM_AUX_DLY_STAGES; gi++) begin : g_dly
            assign dly_next[gi] = dly_reg[gi-1];
        end
    endgenerate

    // Source pick, divide by 2*(code+1) on source rising edges, delay tap
    always_comb begin
        src = aux_ctrl_a[`OOM_AUX_RING_BIT] ? ring_osc_in :
              (aux_ctrl_b[`OOM_AUX_XTAL_BIT] ? xtal_clk_in : vco_clk_in);
        src_prev_next = src;
        cnt_next = cnt_reg;
        div_next = div_reg;
        if (div_code == `OOM_AUX_DIV_BYPASS) begin
            div_next = src;
            cnt_next = 3'h0;
        end else if (src && !src_prev_reg) begin
            if (cnt_reg >= div_code) begin
                cnt_next = 3'h0;
                div_next = !div_reg;
            end else begin
                cnt_next = cnt_reg + 3'h1;
            end
        end
        // Tap zero skips the line entirely
        if (dly_sel == 2'h0) begin
            aux_next = div_reg;
        end else begin
            aux_next = dly_reg[dly_sel - 2'h1];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            src_prev_reg <= 1'b0;
            cnt_reg <= 3'h0;
            div_reg <= 1'b0;
            dly_reg <= '0;
            aux_clk <= 1'b0;
        end else begin
            src_prev_reg <= src_prev_next;
            cnt_reg <= cnt_next;
            div_reg <= div_next;
            dly_reg <= dly_next;
            aux_clk <= aux_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_aux_divtoggle;
        (div_code != `OOM_AUX_DIV_BYPASS) && $stable(div_code) && src && !src_prev_reg
            && (cnt_reg < div_code) |=> $stable(div_reg);
    endproperty
    a_aux_divtoggle: assert property (p_aux_divtoggle) else $error("Divider toggled early");

    property p_aux_delay;
        (dly_sel == 2'h2) && $stable(dly_sel) |=> aux_clk == $past(div_reg, 3);
    endproperty
    a_aux_delay: assert property (p_aux_delay) else $error("Delay tap two wrong");
endmodule : oom_aux_clock

// [logic/oom_view_mux.sv]
// Three-pin observation output mux with its serial register port
//
// Overview of operation
// - Code 3 shows slip indicators and strobe
// - Slip indicators active only during pull-in
// - Max-gain strobe holds from change until lock
// - Fraction write yields synchronized modulator update strobe
// - Code 4 shows strobe, ref divider, sine
// - Code 6 shows accumulator top three bits
// - Code 7 shows aux, ring, modulator clocks
// - Aux source chosen by two control registers
// - Aux delay chosen by two-bit field
// - Aux divide by even ratio 2..14
// - Code 10 shows modulator output low bits
// - Code 0 shows static three-bit data
// - Code 1 shows crystal, ref divider, prescaler
// - Code 2 shows lock window, up, down
`timescale 1ns/1ps
`include "oom_params.svh"
module oom_view_mux
    import oom_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Serial register port
    input wire logic ser_clk,
    input wire logic ser_en,
    input wire logic ser_din,
    output logic ser_dout,
    // Phase detector and lock status
    input wire logic ref_faster,
    input wire logic vco_faster,
    input wire logic lock_detect_in,
    input wire logic lock_window,
    input wire logic pfd_up,
    input wire logic pfd_dn,
    // Reference and prescaler paths
    input wire logic xtal_buf,
    input wire logic sine_ref,
    input wire logic ref_div_out,
    input wire logic vco_presc_out,
    // Modulator taps and clocks
    input wire logic [2:0] dsm_acc_msbs,
    input wire logic [2:0] dsm_out_lsbs,
    input wire logic dsm_clk,
    input wire logic vco_clk_in,
    input wire logic xtal_clk_in,
    input wire logic ring_osc_in,
    // Modulator update strobe
    output logic frac_update_strobe,
    // Probe pins
    output logic probe_pin_one,
    output logic probe_pin_two,
    output logic probe_pin_three
);
    oom_ser_state_t ser_state_reg, ser_state_next;
    logic ser_clk_prev_reg;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [29:0] shift_reg, shift_next;
    oom_word_t rd_shift_reg, rd_shift_next;
    logic ser_dout_next;
    logic wr_commit;
    oom_addr_t wr_addr;
    oom_word_t wr_data;
    oom_word_t aux_a_reg, aux_a_next;
    oom_word_t aux_b_reg, aux_b_next;
    oom_word_t view_reg, view_next;
    logic strobe_next;
    logic pullin_reg, pullin_next;
    logic [2:0] pins_next;
    logic aux_clk;
    logic [3:0] view_sel;

    assign view_sel = view_reg[`OOM_SEL_MSB:`OOM_SEL_LSB];

    // Address match, shared by write decode and read-back
    function automatic logic addr_hit(input oom_addr_t a, input oom_addr_t ofs);
        return a == ofs;
    endfunction : addr_hit

    // Read-back data; unmapped addresses read zero
    function automatic oom_word_t read_word(input oom_addr_t a, input oom_word_t ra,
                                            input oom_word_t rb, input oom_word_t rv,
                                            input logic pull);
        oom_word_t w;
        w = '0;
        if (addr_hit(a, `OOM_OFS_AUX_A)) begin
            w = ra;
        end else if (addr_hit(a, `OOM_OFS_AUX_B)) begin
            w = rb;
        end else if (addr_hit(a, `OOM_OFS_VIEW)) begin
            w = rv;
        end else if (addr_hit(a, `OOM_OFS_STATUS)) begin
            w[`OOM_STAT_PULLIN_BIT] = pull;
        end
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // Serial port: bits taken on each sampled rising edge of ser_clk
    always_comb begin
        ser_state_next = ser_state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        rd_shift_next = rd_shift_reg;
        wr_commit = 1'b0;
        wr_addr = shift_reg[28:23];
        wr_data = {shift_reg[22:0], ser_din};
        if (!ser_en) begin
            // Dropping enable abandons a partial frame with no write
            ser_state_next = OOM_SER_IDLE;
            bit_cnt_next = 5'd0;
        end else if (ser_state_reg == OOM_SER_DONE) begin
            ser_state_next = OOM_SER_DONE;
        end else if (ser_clk && !ser_clk_prev_reg) begin
            ser_state_next = OOM_SER_SHIFT;
            shift_next = {shift_reg[28:0], ser_din};
            bit_cnt_next = bit_cnt_reg + 5'd1;
            rd_shift_next = {rd_shift_reg[22:0], 1'b0};
            if (bit_cnt_reg == `OOM_HEAD_W - 5'd1 && !shift_reg[5]) begin
                rd_shift_next = read_word({shift_reg[4:0], ser_din}, aux_a_reg, aux_b_reg,
                                          view_reg, pullin_reg);
            end
            if (bit_cnt_reg == `OOM_FRAME_W - 5'd1) begin
                ser_state_next = OOM_SER_DONE;
                wr_commit = shift_reg[29];
            end
        end
        ser_dout_next = rd_shift_next[23];
    end

    // Register writes
    always_comb begin
        aux_a_next = aux_a_reg;
        aux_b_next = aux_b_reg;
        view_next = view_reg;
        if (wr_commit) begin
            if (addr_hit(wr_addr, `OOM_OFS_AUX_A)) begin
                aux_a_next = wr_data;
            end else if (addr_hit(wr_addr, `OOM_OFS_AUX_B)) begin
                aux_b_next = wr_data;
            end else if (addr_hit(wr_addr, `OOM_OFS_VIEW)) begin
                view_next = wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Update strobe and pull-in tracking
    always_comb begin
        strobe_next = wr_commit && addr_hit(wr_addr, `OOM_OFS_FRAC);
        // A new frequency command wins over a lock seen in the same cycle
        if (frac_update_strobe) begin
            pullin_next = 1'b1;
        end else if (lock_detect_in) begin
            pullin_next = 1'b0;
        end else begin
            pullin_next = pullin_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Auxiliary clock generator
    oom_aux_clock u_aux_clock (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .aux_ctrl_a(aux_a_reg),
        .aux_ctrl_b(aux_b_reg),
        .vco_clk_in(vco_clk_in),
        .xtal_clk_in(xtal_clk_in),
        .ring_osc_in(ring_osc_in),
        .aux_clk(aux_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin selection, ordered {three, two, one}
    always_comb begin
        case (view_sel)
            `OOM_VIEW_DATA: pins_next = view_reg[`OOM_DATA0_MSB:`OOM_DATA0_LSB];
            `OOM_VIEW_PATHS: pins_next = {xtal_buf, ref_div_out, vco_presc_out};
            `OOM_VIEW_LOCKWIN: pins_next = {pfd_up, pfd_dn, lock_window};
            `OOM_VIEW_SLIP: begin
                // Indicators gated so they only move during pull-in
                pins_next = {ref_faster && pullin_reg, vco_faster && pullin_reg, pullin_reg};
            end
            `OOM_VIEW_FRAC: pins_next = {sine_ref, ref_div_out, frac_update_strobe};
            `OOM_VIEW_ACCUM: pins_next = dsm_acc_msbs;
            `OOM_VIEW_AUX: pins_next = {aux_clk, ring_osc_in, dsm_clk};
            `OOM_VIEW_DSMOUT: pins_next = dsm_out_lsbs;
            default: pins_next = 3'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; pins retimed so a selector change cannot glitch them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ser_state_reg <= OOM_SER_IDLE;
            ser_clk_prev_reg <= 1'b0;
            bit_cnt_reg <= 5'd0;
            shift_reg <= '0;
            rd_shift_reg <= '0;
            ser_dout <= 1'b0;
            aux_a_reg <= `OOM_REG_RESET;
            aux_b_reg <= `OOM_REG_RESET;
            view_reg <= `OOM_REG_RESET;
            frac_update_strobe <= 1'b0;
            pullin_reg <= 1'b0;
            {probe_pin_three, probe_pin_two, probe_pin_one} <= 3'h0;
        end else begin
            ser_state_reg <= ser_state_next;
            ser_clk_prev_reg <= ser_clk;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            rd_shift_reg <= rd_shift_next;
            ser_dout <= ser_dout_next;
            aux_a_reg <= aux_a_next;
            aux_b_reg <= aux_b_next;
            view_reg <= view_next;
            frac_update_strobe <= strobe_next;
            pullin_reg <= pullin_next;
            {probe_pin_three, probe_pin_two, probe_pin_one} <= pins_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_slip_view;
        view_sel == `OOM_VIEW_SLIP |=> probe_pin_one == $past(pullin_reg)
            && probe_pin_three == $past(ref_faster && pullin_reg);
    endproperty
    a_slip_view: assert property (p_slip_view) else $error("Slip view wrong");

    property p_slip_quiet;
        (view_sel == `OOM_VIEW_SLIP) && !pullin_reg |=> !probe_pin_two && !probe_pin_three;
    endproperty
    a_slip_quiet: assert property (p_slip_quiet) else $error("Indicator outside pull-in");

    property p_hold_until_lock;
        frac_update_strobe |=> pullin_reg ##1 (pullin_reg || $past(lock_detect_in));
    endproperty
    a_hold_until_lock: assert property (p_hold_until_lock) else $error("Strobe dropped early");

    property p_frac_strobe;
        wr_commit && addr_hit(wr_addr, `OOM_OFS_FRAC) |=> frac_update_strobe ##1 !frac_update_strobe;
    endproperty
    a_frac_strobe: assert property (p_frac_strobe) else $error("Update strobe missing");

    property p_frac_view;
        view_sel == `OOM_VIEW_FRAC |=> probe_pin_one == $past(frac_update_strobe)
            && probe_pin_three == $past(sine_ref);
    endproperty
    a_frac_view: assert property (p_frac_view) else $error("Frac view wrong");

    property p_accum_view;
        view_sel == `OOM_VIEW_ACCUM |=> {probe_pin_three, probe_pin_two, probe_pin_one} == $past(dsm_acc_msbs);
    endproperty
    a_accum_view: assert property (p_accum_view) else $error("Accumulator view wrong");

    property p_aux_view;
        view_sel == `OOM_VIEW_AUX |=> probe_pin_two == $past(ring_osc_in) && probe_pin_one == $past(dsm_clk);
    endproperty
    a_aux_view: assert property (p_aux_view) else $error("Aux view wrong");

    property p_dsmout_view;
        view_sel == `OOM_VIEW_DSMOUT |=> probe_pin_one == $past(dsm_out_lsbs[0])
            && probe_pin_three == $past(dsm_out_lsbs[2]);
    endproperty
    a_dsmout_view: assert property (p_dsmout_view) else $error("Modulator view wrong");

    property p_data_view;
        view_sel == `OOM_VIEW_DATA |=> {probe_pin_three, probe_pin_two, probe_pin_one}
            == $past(view_reg[`OOM_DATA0_MSB:`OOM_DATA0_LSB]);
    endproperty
    a_data_view: assert property (p_data_view) else $error("Static data view wrong");

    property p_undefined_low;
        view_sel inside {4'h5, 4'h8, 4'h9, [4'hB:4'hF]} |=> !probe_pin_one && !probe_pin_two && !probe_pin_three;
    endproperty
    a_undefined_low: assert property (p_undefined_low) else $error("Undefined code not low");
endmodule : oom_view_mux

// [tb/oom_probe_observer.sv]
// Instrument model that watches the three probe pins
`timescale 1ns/1ps
module oom_probe_observer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Observed pins
    input wire logic probe_pin_one,
    input wire logic probe_pin_two,
    input wire logic probe_pin_three,
    // Captured view, pin three in the top bit
    output logic [2:0] pins_seen
);
    // Sample like a scope on the system clock; a pin is never driven from here
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pins_seen <= 3'h0;
        end else begin
            pins_seen <= {probe_pin_three, probe_pin_two, probe_pin_one};
        end
    end
endmodule : oom_probe_observer

// [tb/oom_view_mux_tb_top.sv]
// Self-checking bench for the observation mux
`timescale 1ns/1ps
`include "oom_params.svh"
module oom_view_mux_tb_top
    import oom_pkg::*;
;
    logic clk_sys, reset_n, ser_clk, ser_en, ser_din, ser_dout;
    logic ref_faster, vco_faster, lock_detect_in, lock_window, pfd_up, pfd_dn;
    logic xtal_buf, sine_ref, ref_div_out, vco_presc_out;
    logic [2:0] dsm_acc_msbs, dsm_out_lsbs, pins_seen, pins_prev_reg, view_data;
    logic dsm_clk, vco_clk_in, xtal_clk_in, ring_osc_in, frac_update_strobe;
    logic probe_pin_one, probe_pin_two, probe_pin_three, pull_exp;
    logic [3:0] sel;
    logic [3:0] codes [15] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    oom_addr_t rd_ofs [5] = '{`OOM_OFS_AUX_A, `OOM_OFS_AUX_B, `OOM_OFS_VIEW, `OOM_OFS_STATUS, 6'h05};
    oom_word_t exp_q [$];
    oom_word_t seen_word, rd, wv;
    int failures, check_count, cnt, k, per, hits, pin_hits, strobe_cnt;
    event look_ev;

    oom_view_mux oom_view_mux_i (.clk_sys(clk_sys), .reset_n(reset_n), .ser_clk(ser_clk), .ser_en(ser_en),
        .ser_din(ser_din), .ser_dout(ser_dout), .ref_faster(ref_faster), .vco_faster(vco_faster),
        .lock_detect_in(lock_detect_in), .lock_window(lock_window), .pfd_up(pfd_up), .pfd_dn(pfd_dn),
        .xtal_buf(xtal_buf), .sine_ref(sine_ref), .ref_div_out(ref_div_out), .vco_presc_out(vco_presc_out),
        .dsm_acc_msbs(dsm_acc_msbs), .dsm_out_lsbs(dsm_out_lsbs), .dsm_clk(dsm_clk), .vco_clk_in(vco_clk_in),
        .xtal_clk_in(xtal_clk_in), .ring_osc_in(ring_osc_in), .frac_update_strobe(frac_update_strobe),
        .probe_pin_one(probe_pin_one), .probe_pin_two(probe_pin_two), .probe_pin_three(probe_pin_three));

    oom_probe_observer oom_probe_observer_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .probe_pin_one(probe_pin_one), .probe_pin_two(probe_pin_two), .probe_pin_three(probe_pin_three),
        .pins_seen(pins_seen));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and sampled source waveforms of periods 2, 4 and 6 cycles
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        cnt <= cnt + 1;
        vco_clk_in <= cnt[0];
        dsm_clk <= cnt[0];
        xtal_clk_in <= cnt[1];
        ring_osc_in <= (cnt % 6) < 3;
    end
    // Previous view, for edge finding
    always @(posedge clk_sys) pins_prev_reg <= pins_seen;
    // Strobe lasts one cycle, often inside a frame task, so count it here
    always @(negedge clk_sys) begin
        if (frac_update_strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic check_val(input oom_word_t seen, input oom_word_t exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check_val

    // Note an expectation and hand the result to the watcher
    task automatic note(input oom_word_t e, input oom_word_t v);
        exp_q.push_back(e);
        seen_word = v;
        -> look_ev;
        #1;
    endtask : note

    // One serial frame, captured read data returned in q
    task automatic frame(input logic wr, input oom_addr_t a, input oom_word_t d, output oom_word_t q);
        logic [30:0] bits;
        int i;
        bits = {wr, a, d};
        q = 24'h0;
        @(negedge clk_sys);
        ser_en = 1'b1;
        for (i = 0; i < 31; i++) begin
            ser_clk = 1'b0;
            ser_din = bits[30 - i];
            @(negedge clk_sys);
            ser_clk = 1'b1;
            if (i >= 7) q[30 - i] = ser_dout;
            @(negedge clk_sys);
        end
        // Frames need a gap with the enable low
        ser_en = 1'b0;
        ser_clk = 1'b0;
        @(negedge clk_sys);
    endtask : frame

    task automatic rand_inputs();
        logic [14:0] r;
        r = 15'($urandom);
        @(negedge clk_sys);
        {ref_faster, vco_faster, lock_window, pfd_up, pfd_dn, xtal_buf, sine_ref, ref_div_out, vco_presc_out} = r[8:0];
        dsm_acc_msbs = r[11:9];
        dsm_out_lsbs = r[14:12];
    endtask : rand_inputs

    function automatic logic [2:0] exp_pins(input logic [3:0] s);
        case (s)
            `OOM_VIEW_DATA: return view_data;
            `OOM_VIEW_PATHS: return {xtal_buf, ref_div_out, vco_presc_out};
            `OOM_VIEW_LOCKWIN: return {pfd_up, pfd_dn, lock_window};
            `OOM_VIEW_SLIP: return {ref_faster & pull_exp, vco_faster & pull_exp, pull_exp};
            `OOM_VIEW_FRAC: return {sine_ref, ref_div_out, 1'b0};
            `OOM_VIEW_ACCUM: return dsm_acc_msbs;
            `OOM_VIEW_DSMOUT: return dsm_out_lsbs;
            default: return 3'h0;
        endcase
    endfunction : exp_pins

    // Mux plus scope add two edges; a third covers the pull-in flag
    task automatic pin_check(input logic [2:0] e);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        note({21'h0, e}, {21'h0, pins_seen});
    endtask : pin_check

    // Period between the second and third rising edge of one pin
    task automatic measure(input int b, output int p);
        int n, r, t0;
        r = 0;
        t0 = 0;
        p = 0;
        for (n = 0; n < 400 && r < 3; n++) begin
            @(negedge clk_sys);
            if (pins_seen[b] === 1'b1 && pins_prev_reg[b] === 1'b0) begin
                r++;
                if (r == 2) t0 = n;
                if (r == 3) p = n - t0;
            end
        end
        if (r < 3) begin
            failures++;
            test_done();
        end
    endtask : measure

    ////////////////////////////////////////////////////////////////////////
    // Watcher: compares each result with the oldest note
    initial begin
        forever begin
            @(look_ev);
            if (exp_q.size() == 0) begin
                failures++;
            end else begin
                check_val(seen_word, exp_q.pop_front());
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {ser_clk, ser_en, ser_din, lock_detect_in, pull_exp, view_data, cnt} = '0;
        {ref_faster, vco_faster, lock_window, pfd_up, pfd_dn, xtal_buf, sine_ref, ref_div_out, vco_presc_out} = '0;
        {dsm_acc_msbs, dsm_out_lsbs, vco_clk_in, xtal_clk_in, ring_osc_in, dsm_clk} = '0;
        failures = 0;
        check_count = 0;
        strobe_cnt = 0;
        void'($urandom(32'hA3F105CE));
        reset_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        pin_check(3'h0);
        // Reset values, status and an unmapped place after a stray write
        frame(1'b1, 6'h05, 24'hFFFFFF, rd);
        foreach (rd_ofs[j]) begin
            frame(1'b0, rd_ofs[j], 24'h0, rd);
            note(24'h0, rd);
        end
        wv = 24'($urandom);
        frame(1'b1, `OOM_OFS_AUX_B, wv, rd);
        frame(1'b0, `OOM_OFS_AUX_B, 24'h0, rd);
        note(wv, rd);
        // Every selector code except 7 (aux) with random waveforms, no pull-in yet
        foreach (codes[j]) begin
            view_data = 3'($urandom);
            sel = codes[j];
            frame(1'b1, `OOM_OFS_VIEW, {17'h0, view_data, sel}, rd);
            for (k = 0; k < 3; k++) begin
                rand_inputs();
                pin_check(exp_pins(sel));
            end
        end
        // Fraction write: one strobe, seen on pin one
        frame(1'b1, `OOM_OFS_VIEW, {20'h0, `OOM_VIEW_FRAC}, rd);
        sine_ref = 1'b0;
        ref_div_out = 1'b0;
        hits = strobe_cnt;
        frame(1'b1, `OOM_OFS_FRAC, 24'($urandom), rd);
        pin_hits = 0;
        for (k = 0; k < 10; k++) begin
            @(negedge clk_sys);
            if (pins_seen[0] === 1'b1) pin_hits++;
        end
        note(24'h1, 24'(strobe_cnt - hits));
        note(24'h1, 24'(pin_hits));
        // Pull-in holds until lock
        pull_exp = 1'b1;
        sel = `OOM_VIEW_SLIP;
        frame(1'b1, `OOM_OFS_VIEW, {20'h0, sel}, rd);
        for (k = 0; k < 4; k++) begin
            rand_inputs();
            pin_check(exp_pins(sel));
        end
        frame(1'b0, `OOM_OFS_STATUS, 24'h0, rd);
        note(24'h1, rd);
        lock_detect_in = 1'b1;
        pull_exp = 1'b0;
        pin_check(exp_pins(sel));
        frame(1'b0, `OOM_OFS_STATUS, 24'h0, rd);
        note(24'h0, rd);
        // Auxiliary clock: divide codes 0 to 6 (not bypass code 7), then each source
        frame(1'b1, `OOM_OFS_VIEW, {20'h0, `OOM_VIEW_AUX}, rd);
        frame(1'b1, `OOM_OFS_AUX_B, 24'h0, rd);
        for (k = 0; k < 7; k++) begin
            frame(1'b1, `OOM_OFS_AUX_A, 24'(k << 4), rd);
            measure(2, per);
            note(24'(4 * (k + 1)), 24'(per));
        end
        measure(1, per);
        note(24'h6, 24'(per));
        measure(0, per);
        note(24'h2, 24'(per));
        frame(1'b1, `OOM_OFS_AUX_B, 24'h1, rd);
        frame(1'b1, `OOM_OFS_AUX_A, 24'h0, rd);
        measure(2, per);
        note(24'h8, 24'(per));
        frame(1'b1, `OOM_OFS_AUX_A, 24'h9, rd);
        measure(2, per);
        note(24'hC, 24'(per));
        test_done();
    end
endmodule : oom_view_mux_tb_top
